// File: core/pin_config_bank.sv
// Pin configuration bank: five pin registers behind an APB slave
//
// Behaviour
// - Bits 2:0 select GPIO or alternate role
// - Pin three alternate is timer match 0
// - Pin four resets to I2C clock, open-drain
// - Pin five alternate is I2C data
// - Pin six alternate is SPI clock
// - Pin seven alternate is timer match 1
// - Bits 4:3 conditioning, bit 5 filter
// - Bit 6 picks voltage or current driver
// - Bit 7 picks high or ultra-high drive
// - Bits 15:8 current level when low
// - Bits 23:16 high level, reset 80h
// - I2C pads bits 9:8 output style
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
module pin_config_bank
  import pin_config_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output pad_config_t port_pin_three,
  output pad_config_t port_pin_four,
  output pad_config_t port_pin_five,
  output pad_config_t port_pin_six,
  output pad_config_t port_pin_seven,
  output logic timer16_match0_sel,
  output logic i2c_clock_sel,
  output logic i2c_data_sel,
  output logic spi_clock_sel,
  output logic timer16_match1_sel,
  output logic pin_four_open_drain,
  output logic pin_five_open_drain
);

  localparam logic [31:0] PIN_ADDR [PIN_COUNT] = '{PIN3_OFFSET, PIN4_OFFSET, PIN5_OFFSET,
    PIN6_OFFSET, PIN7_OFFSET};
  localparam logic [31:0] PIN_MASK [PIN_COUNT] = '{MASK_HIGH_DRIVE, MASK_I2C, MASK_I2C,
    MASK_GENERAL, MASK_HIGH_DRIVE};
  localparam logic [31:0] PIN_RESET [PIN_COUNT] = '{RESET_HIGH_DRIVE, RESET_I2C, RESET_I2C,
    RESET_GENERAL, RESET_HIGH_DRIVE};

  logic [31:0] pin_value [PIN_COUNT];
  logic [PIN_COUNT-1:0] hit;
  logic access_phase;
  logic [31:0] read_mux;
  logic [31:0] prdata_next;

  // Zero-wait slave; pready is combinational from the access phase
  assign access_phase = psel && penable;
  assign pready = access_phase;
  assign pslverr = access_phase && (hit == '0);

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_pin
      assign hit[g] = (paddr == PIN_ADDR[g]);
      pin_config_slot #(
        .WRITE_MASK(PIN_MASK[g]),
        .RESET_VALUE(PIN_RESET[g])
      ) u_slot (
        .pclk(pclk),
        .presetn(presetn),
        .write_strobe(access_phase && pwrite && hit[g]),
        .write_data(pwdata),
        .value_reg(pin_value[g])
      );
    end
  endgenerate

  always_comb begin
    read_mux = 32'h00000000;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (hit[i]) begin
        read_mux = pin_value[i];
      end
    end
  end

  // Read data held in a flop; valid on the setup cycle so it stands in the access phase
  assign prdata_next = (psel && !penable && !pwrite) ? read_mux : prdata;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= prdata_next;
    end
  end

  function automatic pad_config_t unpack_general(input logic [31:0] v);
    pad_config_t c;
    c = '0;
    c.pin_role_select = v[ROLE_MSB:ROLE_LSB];
    c.conditioning = v[COND_MSB:COND_LSB];
    c.glitch_filter_enable = v[FILTER_BIT];
    c.driver_type_select = v[DRIVER_TYPE_BIT];
    c.drive_strength_select = v[STRENGTH_BIT];
    c.current_low_level = v[CUR_LO_MSB:CUR_LO_LSB];
    c.current_high_level = v[CUR_HI_MSB:CUR_HI_LSB];
    return c;
  endfunction : unpack_general

  function automatic pad_config_t unpack_i2c(input logic [31:0] v);
    pad_config_t c;
    c = '0;
    c.pin_role_select = v[ROLE_MSB:ROLE_LSB];
    c.pad_output_style = v[STYLE_MSB:STYLE_LSB];
    return c;
  endfunction : unpack_i2c

  assign port_pin_three = unpack_general(pin_value[0]);
  assign port_pin_four = unpack_i2c(pin_value[1]);
  assign port_pin_five = unpack_i2c(pin_value[2]);
  assign port_pin_six = unpack_general(pin_value[3]);
  assign port_pin_seven = unpack_general(pin_value[4]);

  // Disallowed role codes fall back to GPIO routing
  assign timer16_match0_sel = (port_pin_three.pin_role_select == ROLE_ALT);
  assign i2c_clock_sel = (port_pin_four.pin_role_select == ROLE_ALT);
  assign i2c_data_sel = (port_pin_five.pin_role_select == ROLE_ALT);
  assign spi_clock_sel = (port_pin_six.pin_role_select == ROLE_ALT);
  assign timer16_match1_sel = (port_pin_seven.pin_role_select == ROLE_ALT);

  // Both roles of the I2C pads are open-drain
  assign pin_four_open_drain = 1'b1;
  assign pin_five_open_drain = 1'b1;

  // Stored words keep reserved bits clear; reset words per pad kind
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_value[0] & ~MASK_HIGH_DRIVE) == '0) && ((pin_value[1] & ~MASK_I2C) == '0)
    && ((pin_value[2] & ~MASK_I2C) == '0) && ((pin_value[3] & ~MASK_GENERAL) == '0)
    && ((pin_value[4] & ~MASK_HIGH_DRIVE) == '0))
    else $error("reserved bits not zero");

  a_reset_words: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> pin_value[0] == RESET_HIGH_DRIVE && pin_value[1] == RESET_I2C
    && pin_value[2] == RESET_I2C && pin_value[3] == RESET_GENERAL
    && pin_value[4] == RESET_HIGH_DRIVE)
    else $error("reset words wrong");

  a_reset_routes: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> i2c_clock_sel && i2c_data_sel && !timer16_match0_sel
    && !spi_clock_sel && !timer16_match1_sel)
    else $error("reset routing wrong");

  // Writes land only at an access-phase edge, masked per pad kind
  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && pwrite && hit[4] |=> pin_value[4] == ($past(pwdata) & MASK_HIGH_DRIVE))
    else $error("pin seven write not stored");

  a_write_pin3: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && pwrite && hit[0] |=> pin_value[0] == ($past(pwdata) & MASK_HIGH_DRIVE))
    else $error("pin three write not stored");

  a_write_pin4: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && pwrite && hit[1] |=> pin_value[1] == ($past(pwdata) & MASK_I2C))
    else $error("pin four write not stored");

  a_write_pin5: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && pwrite && hit[2] |=> pin_value[2] == ($past(pwdata) & MASK_I2C))
    else $error("pin five write not stored");

  a_write_pin6: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && pwrite && hit[3] |=> pin_value[3] == ($past(pwdata) & MASK_GENERAL))
    else $error("pin six write not stored");

  a_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && pwrite && hit == '0 |=> $stable(pin_value[0]) && $stable(pin_value[1])
    && $stable(pin_value[2]) && $stable(pin_value[3]) && $stable(pin_value[4]))
    else $error("unmapped write changed a register");

  a_idle_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !access_phase |=> $stable(pin_value[0]) && $stable(pin_value[1])
    && $stable(pin_value[2]) && $stable(pin_value[3]) && $stable(pin_value[4]))
    else $error("register changed outside an access");

  // Read word is loaded at the setup edge and stands until the next read
  a_read_returns: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit[0] |=> prdata == $past(pin_value[0]))
    else $error("pin three read data wrong");

  a_read_pin4: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit[1] |=> prdata == $past(pin_value[1]))
    else $error("pin four read data wrong");

  a_read_pin5: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit[2] |=> prdata == $past(pin_value[2]))
    else $error("pin five read data wrong");

  a_read_pin6: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit[3] |=> prdata == $past(pin_value[3]))
    else $error("pin six read data wrong");

  a_read_pin7: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit[4] |=> prdata == $past(pin_value[4]))
    else $error("pin seven read data wrong");

  a_read_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit == '0 |=> prdata == '0)
    else $error("unmapped read not zero");

  a_read_stands: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase && hit == '0 |-> pslverr && pready)
    else $error("unmapped access not refused");

  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable) |-> !pready && !pslverr)
    else $error("bus answer outside an access");

  a_hit_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(hit))
    else $error("address decodes to two registers");

  // Only code 001b routes the alternate role; other codes stay GPIO
  a_timer0_route: assert property (@(posedge pclk) disable iff (!presetn)
    timer16_match0_sel == (pin_value[0][ROLE_MSB:ROLE_LSB] == ROLE_ALT))
    else $error("timer match 0 routing wrong");

  a_i2c_route: assert property (@(posedge pclk) disable iff (!presetn)
    i2c_data_sel == (pin_value[2][ROLE_MSB:ROLE_LSB] == ROLE_ALT)
    && i2c_clock_sel == (pin_value[1][ROLE_MSB:ROLE_LSB] == ROLE_ALT))
    else $error("I2C routing wrong");

  a_spi_route: assert property (@(posedge pclk) disable iff (!presetn)
    spi_clock_sel == (pin_value[3][ROLE_MSB:ROLE_LSB] == ROLE_ALT))
    else $error("SPI clock routing wrong");

  a_timer1_route: assert property (@(posedge pclk) disable iff (!presetn)
    timer16_match1_sel == (pin_value[4][ROLE_MSB:ROLE_LSB] == ROLE_ALT))
    else $error("timer match 1 routing wrong");

  a_role_fields: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_three.pin_role_select == pin_value[0][ROLE_MSB:ROLE_LSB]
    && port_pin_four.pin_role_select == pin_value[1][ROLE_MSB:ROLE_LSB]
    && port_pin_five.pin_role_select == pin_value[2][ROLE_MSB:ROLE_LSB]
    && port_pin_six.pin_role_select == pin_value[3][ROLE_MSB:ROLE_LSB]
    && port_pin_seven.pin_role_select == pin_value[4][ROLE_MSB:ROLE_LSB])
    else $error("role field decode wrong");

  a_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
    pin_four_open_drain && pin_five_open_drain)
    else $error("I2C pad not open-drain");

  // Field decode per pad kind; fields a pad lacks stay zero
  a_fields_map: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_seven.conditioning == pin_value[4][COND_MSB:COND_LSB]
    && port_pin_seven.glitch_filter_enable == pin_value[4][FILTER_BIT]
    && port_pin_seven.driver_type_select == pin_value[4][DRIVER_TYPE_BIT]
    && port_pin_seven.drive_strength_select == pin_value[4][STRENGTH_BIT])
    else $error("pin seven field map wrong");

  a_fields_pin3: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_three.conditioning == pin_value[0][COND_MSB:COND_LSB]
    && port_pin_three.glitch_filter_enable == pin_value[0][FILTER_BIT]
    && port_pin_three.driver_type_select == pin_value[0][DRIVER_TYPE_BIT]
    && port_pin_three.drive_strength_select == pin_value[0][STRENGTH_BIT])
    else $error("pin three field map wrong");

  a_levels_pin3: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_three.current_low_level == pin_value[0][CUR_LO_MSB:CUR_LO_LSB]
    && port_pin_three.current_high_level == pin_value[0][CUR_HI_MSB:CUR_HI_LSB])
    else $error("pin three current levels wrong");

  a_levels_pin7: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_seven.current_low_level == pin_value[4][CUR_LO_MSB:CUR_LO_LSB]
    && port_pin_seven.current_high_level == pin_value[4][CUR_HI_MSB:CUR_HI_LSB])
    else $error("pin seven current levels wrong");

  a_fields_pin6: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_six.conditioning == pin_value[3][COND_MSB:COND_LSB]
    && port_pin_six.glitch_filter_enable == pin_value[3][FILTER_BIT])
    else $error("pin six field map wrong");

  a_pin6_unused: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_six.driver_type_select == 1'b0 && port_pin_six.drive_strength_select == 1'b0
    && port_pin_six.current_low_level == '0 && port_pin_six.current_high_level == '0)
    else $error("pin six drive fields not zero");

  a_style_map: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_four.pad_output_style == pin_value[1][STYLE_MSB:STYLE_LSB])
    else $error("pad output style wrong");

  a_style_pin5: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_five.pad_output_style == pin_value[2][STYLE_MSB:STYLE_LSB])
    else $error("pin five output style wrong");

  a_i2c_unused: assert property (@(posedge pclk) disable iff (!presetn)
    port_pin_four.conditioning == '0 && port_pin_four.glitch_filter_enable == 1'b0
    && port_pin_five.conditioning == '0 && port_pin_five.glitch_filter_enable == 1'b0)
    else $error("I2C pad conditioning not zero");

  c_write_pin3: cover property (@(posedge pclk) access_phase && pwrite && hit[0]);
  c_read_pin4: cover property (@(posedge pclk) access_phase && !pwrite && hit[1]);
  c_unmapped: cover property (@(posedge pclk) pslverr);
  c_spi_alt: cover property (@(posedge pclk) spi_clock_sel);
  c_ultra_drive: cover property (@(posedge pclk) port_pin_seven.drive_strength_select);

endmodule : pin_config_bank

// File: core/pin_config_pkg.sv
// Package with register map, field layout and reset values of the pin configuration bank
package pin_config_pkg;

  localparam logic [31:0] PIN3_OFFSET = 32'h4004400C;
  localparam logic [31:0] PIN4_OFFSET = 32'h40044010;
  localparam logic [31:0] PIN5_OFFSET = 32'h40044014;
  localparam logic [31:0] PIN6_OFFSET = 32'h40044018;
  localparam logic [31:0] PIN7_OFFSET = 32'h4004401C;

  localparam int ROLE_LSB = 0;
  localparam int ROLE_MSB = 2;
  localparam int COND_LSB = 3;
  localparam int COND_MSB = 4;
  localparam int FILTER_BIT = 5;
  localparam int DRIVER_TYPE_BIT = 6;
  localparam int STRENGTH_BIT = 7;
  localparam int CUR_LO_LSB = 8;
  localparam int CUR_LO_MSB = 15;
  localparam int CUR_HI_LSB = 16;
  localparam int CUR_HI_MSB = 23;
  localparam int STYLE_LSB = 8;
  localparam int STYLE_MSB = 9;

  localparam logic [2:0] ROLE_GPIO = 3'h0;
  localparam logic [2:0] ROLE_ALT = 3'h1;
  localparam logic [1:0] STYLE_I2C = 2'h0;
  localparam logic [1:0] STYLE_GPIO = 2'h1;

  // Writable bits per pad kind; everything else reads zero
  localparam logic [31:0] MASK_HIGH_DRIVE = 32'h00FFFFFF;
  localparam logic [31:0] MASK_GENERAL = 32'h0000003F;
  localparam logic [31:0] MASK_I2C = 32'h00000307;

  localparam logic [31:0] RESET_HIGH_DRIVE = 32'h00800000;
  localparam logic [31:0] RESET_GENERAL = 32'h00000000;
  localparam logic [31:0] RESET_I2C = 32'h00000001;

  localparam int PIN_COUNT = 5;

  typedef struct packed {
    logic [2:0] pin_role_select;
    logic [1:0] conditioning;
    logic glitch_filter_enable;
    logic driver_type_select;
    logic drive_strength_select;
    logic [7:0] current_low_level;
    logic [7:0] current_high_level;
    logic [1:0] pad_output_style;
  } pad_config_t;

endpackage : pin_config_pkg

// File: core/pin_config_slot.sv
// One pin configuration register with write mask and reset value
`timescale 1ns/100ps
module pin_config_slot
  import pin_config_pkg::*;
#(
  parameter logic [31:0] WRITE_MASK = MASK_GENERAL,
  parameter logic [31:0] RESET_VALUE = RESET_GENERAL
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic write_strobe,
  input wire logic [31:0] write_data,
  output logic [31:0] value_reg
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= RESET_VALUE;
    end else if (write_strobe) begin
      value_reg <= write_data & WRITE_MASK;
    end
  end

endmodule : pin_config_slot

// File: sim/tb_top.sv
// Self-checking bench for the pin configuration bank
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("FAIL %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  import pin_config_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv, od4, od5;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [4:0] sel;
  pad_config_t p3, p4, p5, p6, p7;
  int err_total, comparisons;
  logic [31:0] addr [5] = '{PIN3_OFFSET, PIN4_OFFSET, PIN5_OFFSET, PIN6_OFFSET, PIN7_OFFSET};
  logic [31:0] rstv [5] = '{RESET_HIGH_DRIVE, RESET_I2C, RESET_I2C, RESET_GENERAL,
    RESET_HIGH_DRIVE};
  logic [31:0] msk [5] = '{MASK_HIGH_DRIVE, MASK_I2C, MASK_I2C, MASK_GENERAL, MASK_HIGH_DRIVE};
  pin_config_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pin_three(p3), .port_pin_four(p4), .port_pin_five(p5),
    .port_pin_six(p6), .port_pin_seven(p7), .timer16_match0_sel(sel[4]),
    .i2c_clock_sel(sel[3]), .i2c_data_sel(sel[2]), .spi_clock_sel(sel[1]),
    .timer16_match1_sel(sel[0]), .pin_four_open_drain(od4), .pin_five_open_drain(od5));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Setup then access; waits on pready, only the watchdog ends a hang
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs launched by the landing edge are settled here
    @(negedge pclk);
  endtask : xfer
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rd_chk
  task automatic reset_values;
    for (int i = 0; i < 5; i++) rd_chk(addr[i], rstv[i]);
    `CHK(sel, 5'h0C)
    `CHK({od4, od5}, 2'h3)
    `CHK(slv, 1'b0)
  endtask : reset_values
  // All-ones write exposes every reserved bit at once
  task automatic mask_check;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, addr[i], 32'hFFFFFFFF);
      rd_chk(addr[i], msk[i]);
    end
    `CHK(p6.driver_type_select, 1'b0)
    `CHK(p4.pad_output_style, 2'h3)
  endtask : mask_check
  task automatic field_check;
    xfer(1'b1, PIN3_OFFSET, 32'h00A5C3C0);
    xfer(1'b1, PIN6_OFFSET, 32'h00000038);
    xfer(1'b1, PIN5_OFFSET, 32'h00000100);
    xfer(1'b1, PIN7_OFFSET, 32'h0000005A);
    `CHK({p3.driver_type_select, p3.drive_strength_select}, 2'h3)
    `CHK(p3.current_low_level, 8'hC3)
    `CHK(p3.current_high_level, 8'hA5)
    `CHK({p6.conditioning, p6.glitch_filter_enable}, 3'h7)
    `CHK({p7.conditioning, p7.glitch_filter_enable, p7.drive_strength_select}, 4'hC)
    `CHK({p7.pin_role_select, p7.driver_type_select}, 4'h5)
    `CHK(p5.pad_output_style, STYLE_GPIO)
  endtask : field_check
  task automatic role_check;
    for (int i = 0; i < 5; i++) xfer(1'b1, addr[i], 32'h00000001);
    `CHK(sel, 5'h1F)
    for (int i = 0; i < 5; i++) xfer(1'b1, addr[i], 32'h00000002);
    `CHK(sel, 5'h00)
    `CHK(p4.pin_role_select, 3'h2)
    xfer(1'b1, PIN4_OFFSET, 32'h00000000);
    `CHK(sel, 5'h00)
  endtask : role_check
  task automatic unmapped_check;
    xfer(1'b1, 32'h40044020, 32'hFFFFFFFF);
    `CHK(slv, 1'b1)
    rd_chk(32'h40044020, 32'h0);
    rd_chk(PIN6_OFFSET, 32'h0);
  endtask : unmapped_check
  task automatic pulse_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : pulse_reset
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
  initial begin
    err_total = 0;
    comparisons = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    mask_check();
    field_check();
    role_check();
    xfer(1'b1, PIN6_OFFSET, 32'h00000000);
    unmapped_check();
    // Mid-run reset must restore every pad
    pulse_reset();
    reset_values();
    stop_test();
  end
endmodule : tb_top
